// ### verilog/ufc_pkg.sv
// constants shared by the uart in-band flow and dma request block
package ufc_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_STATUS = 8'h3c;
   localparam logic [7:0] ADDR_DMA = 8'h48;
   localparam logic [7:0] ADDR_FLOW = 8'h4c;
   localparam logic [7:0] ADDR_RES_A = 8'h54;
   localparam logic [7:0] ADDR_RES_B = 8'h58;
   localparam logic [7:0] ADDR_PAU_A = 8'h5c;
   localparam logic [7:0] ADDR_PAU_B = 8'h60;
   // dma request control fields
   localparam int DMA_RX_EN_BIT = 0;
   localparam int DMA_TX_EN_BIT = 1;
   localparam int DMA_HALT_ERR_BIT = 3;
   localparam logic [31:0] DMA_MASK = 32'h0000000b;
   // in-band flow control fields
   localparam int FLOW_EN_BIT = 0;
   localparam int RX_MODE_LSB = 1;
   localparam int TX_MODE_LSB = 3;
   localparam int RESUME_ANY_BIT = 5;
   localparam int SPECIAL_BIT = 6;
   localparam logic [31:0] FLOW_MASK = 32'h0000007f;
   // raw interrupt status fields
   localparam int ST_FRAME_BIT = 7;
   localparam int ST_PAUSE_BIT = 11;
   // value of every register after reset
   localparam logic [31:0] REG_RESET = 32'h00000000;
   // flow mode encodings
   localparam logic [1:0] MODE_OFF = 2'b00;
   localparam logic [1:0] MODE_A = 2'b01;
   localparam logic [1:0] MODE_B = 2'b10;
   // receive fifo shape and flow thresholds
   localparam int FIFO_DEPTH = 32;
   localparam logic [5:0] LEVEL_HIGH = 6'h18;
   localparam logic [5:0] LEVEL_LOW = 6'h08;
   // transmit suspension state
   typedef enum logic [1:0] {
      TX_RUN = 2'b01,
      TX_HOLD = 2'b10
   } ufc_tx_e;
endpackage

// ### verilog/ufc_top.sv
// uart dma request gating and in-band software flow control
//
// Function
// - receive dma requests only when enabled
// - transmit dma requests only when enabled
// - optionally halt receive dma on errors
// - in-band flow control needs global enable
// - receive mode selects characters we send
// - transmit mode selects characters we obey
// - special character detection when enabled
// - first resume character register, reset zero
// - second resume character register, reset zero
// - first pause character register, reset zero
// - second pause character register, reset zero
// - raw pause interrupt status flag bit
// - error status bits form error interrupt
`timescale 1ns/1ps
`default_nettype none

// synchronous fifo with valid/ready on both sides
module ufc_fifo
   import ufc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH,
   parameter int AW = $clog2(DEPTH)
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);
   logic [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
   logic [AW-1:0] wr_ptr; // next slot to fill
   logic [AW-1:0] rd_ptr; // oldest slot
   logic push; // word enters
   logic pop; // word leaves

   // honest full and empty from the level count
   assign in_ready = (level != DEPTH[AW:0]);
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   // storage write, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and level
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= AW'(wr_ptr + 1'b1);
         end
         if (pop)
         begin
            rd_ptr <= AW'(rd_ptr + 1'b1);
         end
         if (push && !pop)
         begin
            level <= (AW+1)'(level + 1'b1);
         end
         else if (pop && !push)
         begin
            level <= (AW+1)'(level - 1'b1);
         end
      end
   end
endmodule

// top: ahb-lite registers, dma gating, in-band flow control
module ufc_top
   import ufc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   output logic RX_READY,
   input wire logic FRAME_ERR,
   input wire logic PARITY_ERR,
   input wire logic BREAK_ERR,
   input wire logic OVERRUN_ERR,
   output logic RX_DMA_REQ,
   output logic [7:0] RX_DMA_DATA,
   input wire logic RX_DMA_ACK,
   output logic TX_DMA_REQ,
   input wire logic TX_DMA_VALID,
   input wire logic [7:0] TX_DMA_DATA,
   output logic TX_VALID,
   output logic [7:0] TX_DATA,
   input wire logic TX_READY,
   output logic SPECIAL_CHAR
);
   logic [31:0] dma_ctl; // dma request control
   logic [31:0] flow_ctl; // in-band flow control
   logic [7:0] chr [0:3]; // resume a, resume b, pause a, pause b
   logic pause_flag; // raw pause interrupt status
   logic wr_pend; // write data phase pending
   logic rd_wait; // read wait state
   logic [7:0] bus_addr; // latched offset
   logic [31:0] rd_mux; // read value of latched offset
   logic [3:0] err_bits; // overrun, break, parity, framing
   logic err_irq; // any error pending
   ufc_tx_e tx_state; // transmit run or hold
   logic remote_paused; // we have told the far end to pause
   logic [1:0] rx_mode; // characters we send
   logic [1:0] tx_mode; // characters we obey
   logic rx_fc_on; // receive flow active
   logic tx_fc_on; // transmit flow active
   logic rx_fire; // character accepted
   logic pause_hit; // received matching pause
   logic res_hit; // received matching resume
   logic fifo_valid; // fifo holds a character
   logic [5:0] fifo_level; // fifo fill
   logic hold_full; // transmit holding slot busy
   logic [7:0] hold_data; // transmit holding slot
   logic out_free; // transmit output may load
   logic need_pause; // pause character due
   logic need_resume; // resume character due
   logic ld_flow; // flow character loaded
   logic ld_data; // data character loaded
   logic [7:0] flow_chr; // flow character to send

   assign rx_mode = flow_ctl[RX_MODE_LSB +: 2];
   assign tx_mode = flow_ctl[TX_MODE_LSB +: 2];
   // in-band flow needs the global enable
   assign rx_fc_on = flow_ctl[FLOW_EN_BIT] && (rx_mode != MODE_OFF);
   assign tx_fc_on = flow_ctl[FLOW_EN_BIT] && (tx_mode != MODE_OFF);
   assign err_bits = {OVERRUN_ERR, BREAK_ERR, PARITY_ERR, FRAME_ERR};
   assign err_irq = |err_bits;
   assign HRESP = 1'b0;
   assign HREADYOUT = !rd_wait;

   // ahb address phase capture, one wait state on reads
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wr_pend <= 1'b0;
         rd_wait <= 1'b0;
         bus_addr <= '0;
      end
      else if (CE)
      begin
         if (HREADY && HSEL && HTRANS[1])
         begin
            wr_pend <= HWRITE;
            rd_wait <= !HWRITE;
            bus_addr <= HADDR[7:0];
         end
         else
         begin
            wr_pend <= 1'b0;
            rd_wait <= 1'b0;
         end
      end
   end

   // read mux, unmapped offsets read zero
   always_comb
   begin
      rd_mux = '0;
      if (bus_addr == ADDR_DMA)
      begin
         rd_mux = dma_ctl;
      end
      else if (bus_addr == ADDR_FLOW)
      begin
         rd_mux = flow_ctl;
      end
      else if (bus_addr == ADDR_STATUS)
      begin
         rd_mux[ST_FRAME_BIT +: 4] = err_bits;
         rd_mux[ST_PAUSE_BIT] = pause_flag;
      end
      else if (bus_addr == ADDR_RES_A)
      begin
         rd_mux[7:0] = chr[0];
      end
      else if (bus_addr == ADDR_RES_B)
      begin
         rd_mux[7:0] = chr[1];
      end
      else if (bus_addr == ADDR_PAU_A)
      begin
         rd_mux[7:0] = chr[2];
      end
      else if (bus_addr == ADDR_PAU_B)
      begin
         rd_mux[7:0] = chr[3];
      end
   end

   // read data taken in the wait state, after any earlier write
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         HRDATA <= '0;
      end
      else if (CE && rd_wait)
      begin
         HRDATA <= rd_mux;
      end
   end

   // control registers, reserved bits masked off
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         dma_ctl <= REG_RESET;
         flow_ctl <= REG_RESET;
      end
      else if (CE && wr_pend)
      begin
         if (bus_addr == ADDR_DMA)
         begin
            dma_ctl <= HWDATA & DMA_MASK;
         end
         else if (bus_addr == ADDR_FLOW)
         begin
            flow_ctl <= HWDATA & FLOW_MASK;
         end
      end
   end

   // four character registers, eight bits each
   for (genvar i = 0; i < 4; i++)
   begin : g_chr
      localparam logic [7:0] OFS = ADDR_RES_A + 8'(4 * i);
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
         if (!RST_N)
         begin
            chr[i] <= REG_RESET[7:0];
         end
         else if (CE && wr_pend && bus_addr == OFS)
         begin
            chr[i] <= HWDATA[7:0];
         end
      end
      char_store_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
         CE && wr_pend && bus_addr == OFS |=> chr[i] == $past(HWDATA[7:0]))
         else $error("character register missed a write");
   end

   // received character classification
   assign rx_fire = RX_VALID && RX_READY;
   assign pause_hit = tx_fc_on &&
      ((tx_mode[0] && RX_DATA == chr[2]) ||
       (tx_mode[1] && RX_DATA == chr[3]));
   assign res_hit = tx_fc_on &&
      ((tx_mode[0] && RX_DATA == chr[0]) ||
       (tx_mode[1] && RX_DATA == chr[1]));

   // transmit suspension on pause, release on resume
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tx_state <= TX_RUN;
      end
      else if (CE)
      begin
         case (tx_state)
            TX_RUN:
            begin
               if (rx_fire && pause_hit)
               begin
                  tx_state <= TX_HOLD;
               end
            end
            TX_HOLD:
            begin
               if (!tx_fc_on)
               begin
                  tx_state <= TX_RUN;
               end
               else if (rx_fire && !pause_hit &&
                  (flow_ctl[RESUME_ANY_BIT] || res_hit))
               begin
                  tx_state <= TX_RUN;
               end
            end
            default:
            begin
               tx_state <= TX_RUN;
            end
         endcase
      end
   end

   // raw pause status, set wins over a write-one clear
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pause_flag <= 1'b0;
      end
      else if (CE)
      begin
         if (rx_fire && pause_hit)
         begin
            pause_flag <= 1'b1;
         end
         else if (wr_pend && bus_addr == ADDR_STATUS &&
            HWDATA[ST_PAUSE_BIT])
         begin
            pause_flag <= 1'b0;
         end
      end
   end

   // special character detection pulse
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         SPECIAL_CHAR <= 1'b0;
      end
      else if (CE)
      begin
         SPECIAL_CHAR <= rx_fire && flow_ctl[SPECIAL_BIT] &&
            (RX_DATA == chr[0] || RX_DATA == chr[1] ||
             RX_DATA == chr[2] || RX_DATA == chr[3]);
      end
   end

   // receive fifo, flow characters obeyed are not stored
   ufc_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .ce(CE),
      .in_valid(RX_VALID && !pause_hit && !res_hit),
      .in_ready(RX_READY),
      .in_data(RX_DATA),
      .out_valid(fifo_valid),
      .out_ready(RX_DMA_ACK && RX_DMA_REQ),
      .out_data(RX_DMA_DATA),
      .level(fifo_level)
   );

   // receive dma request gating
   assign RX_DMA_REQ = dma_ctl[DMA_RX_EN_BIT] && fifo_valid &&
      !(dma_ctl[DMA_HALT_ERR_BIT] && err_irq);
   // transmit dma request gating
   assign TX_DMA_REQ = dma_ctl[DMA_TX_EN_BIT] && !hold_full;

   // transmit output scheduling, flow characters first
   assign out_free = !TX_VALID || TX_READY;
   assign need_pause = rx_fc_on && !remote_paused &&
      fifo_level >= LEVEL_HIGH;
   assign need_resume = rx_fc_on && remote_paused &&
      fifo_level <= LEVEL_LOW;
   assign flow_chr = (rx_mode == MODE_B) ?
      (need_pause ? chr[3] : chr[1]) :
      (need_pause ? chr[2] : chr[0]);
   assign ld_flow = CE && out_free && (need_pause || need_resume);
   assign ld_data = CE && out_free && !ld_flow && hold_full &&
      tx_state == TX_RUN;

   // transmit holding slot filled by dma
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         hold_full <= 1'b0;
         hold_data <= '0;
      end
      else if (CE)
      begin
         if (TX_DMA_REQ && TX_DMA_VALID)
         begin
            hold_full <= 1'b1;
            hold_data <= TX_DMA_DATA;
         end
         else if (ld_data)
         begin
            hold_full <= 1'b0;
         end
      end
   end

   // transmit output register toward the serializer
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         TX_VALID <= 1'b0;
         TX_DATA <= '0;
      end
      else if (CE && out_free)
      begin
         TX_VALID <= ld_flow || ld_data;
         if (ld_flow)
         begin
            TX_DATA <= flow_chr;
         end
         else if (ld_data)
         begin
            TX_DATA <= hold_data;
         end
      end
   end

   // record whether the far end was told to pause
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         remote_paused <= 1'b0;
      end
      else if (CE)
      begin
         if (!rx_fc_on)
         begin
            remote_paused <= 1'b0;
         end
         else if (ld_flow)
         begin
            remote_paused <= need_pause;
         end
      end
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   rx_dma_gate_a: assert property (RX_DMA_REQ |-> dma_ctl[0])
      else $error("rx dma request while disabled");
   tx_dma_gate_a: assert property (TX_DMA_REQ |-> dma_ctl[1])
      else $error("tx dma request while disabled");
   err_halt_a: assert property (dma_ctl[3] && err_irq |-> !RX_DMA_REQ)
      else $error("rx dma request during error");
   flow_off_a: assert property (CE && !flow_ctl[0] |=> tx_state == TX_RUN)
      else $error("transmit held without flow enable");
   rx_mode_off_a: assert property (CE && !rx_fc_on |=> !remote_paused)
      else $error("pause state kept with receive flow off");
   pause_mode_a: assert property (CE && rx_fire && flow_ctl[0] &&
      tx_mode == MODE_A && RX_DATA == chr[2] |=> tx_state == TX_HOLD)
      else $error("first pause character not obeyed");
   resume_any_a: assert property (CE && rx_fire && tx_state == TX_HOLD &&
      flow_ctl[0] && flow_ctl[5] && !pause_hit |=> tx_state == TX_RUN)
      else $error("resume on any character failed");
   special_gate_a: assert property (SPECIAL_CHAR |-> $past(flow_ctl[6]))
      else $error("special character flagged while disabled");
   pause_flag_a: assert property (CE && rx_fire && pause_hit |=>
      pause_flag)
      else $error("pause status not raised");
   status_read_a: assert property ($fell(rd_wait) && bus_addr == ADDR_STATUS
      |-> HRDATA[10:7] == $past(err_bits))
      else $error("error status read wrong");
   suspend_a: assert property (CE && tx_state == TX_HOLD && hold_full
      |=> hold_full)
      else $error("data sent while suspended");
   reserved_a: assert property ($fell(rd_wait) && bus_addr == ADDR_DMA
      |-> HRDATA[31:4] == '0 && !HRDATA[2])
      else $error("reserved bits read nonzero");

   pause_resume_c: cover property (tx_state == TX_HOLD ##[1:50] tx_state == TX_RUN);
   rx_dma_c: cover property (RX_DMA_REQ && RX_DMA_ACK);
   fifo_full_c: cover property (!RX_READY);
   flow_send_c: cover property (ld_flow);
endmodule
`default_nettype wire

// ### test/ufc_far.sv
// model of the remote serial device and the dma controller
`timescale 1ns/1ps
`default_nettype none

module ufc_far
(
   input wire logic clk,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_req,
   input wire logic [7:0] rx_dma_data,
   output logic rx_ack,
   input wire logic tx_req,
   output logic tx_dvalid,
   output logic [7:0] tx_ddata,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] rxq[$]; // bytes fetched by the dma
   logic [7:0] txq[$]; // bytes seen on the line
   logic slow = 1'b0; // stall the line receiver
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_ack = 1'b1;
      tx_dvalid = 1'b0;
      tx_ddata = 8'h00;
      tx_ready = 1'b1;
   end
   // receiver takes every other cycle while stalled
   always @(posedge clk)
      tx_ready <= slow ? ~tx_ready : 1'b1;
   // collect transfers while all their signals stand still
   always @(negedge clk)
   begin
      if (rx_req && rx_ack)
         rxq.push_back(rx_dma_data);
      if (tx_valid && tx_ready)
         txq.push_back(tx_data);
   end
   // remote sends one character; the released line shows junk
   task send(input logic [7:0] c);
   begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= c;
      @(negedge clk);
      while (rx_ready !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~c;
   end
   endtask
   // dma controller hands one byte when asked
   task dput(input logic [7:0] c);
   begin
      @(posedge clk);
      tx_dvalid <= 1'b1;
      tx_ddata <= c;
      @(negedge clk);
      while (tx_req !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      tx_dvalid <= 1'b0;
      tx_ddata <= ~c;
   end
   endtask
endmodule

`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the dma gating and in-band flow block
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import ufc_pkg::*;
   logic REF_CLK = 1'b0;
   logic RST_N; // driven by the main sequence
   logic HSEL;
   logic HWRITE;
   logic [1:0] HTRANS;
   logic [31:0] HADDR;
   logic [31:0] HWDATA;
   logic [3:0] err; // framing, parity, break, overrun
   logic [31:0] HRDATA, r;
   logic HREADYOUT, HRESP, RX_READY, RX_VALID, RX_DMA_REQ, RX_DMA_ACK;
   logic TX_DMA_REQ, TX_DMA_VALID, TX_VALID, TX_READY, SPECIAL_CHAR;
   logic [7:0] RX_DATA, RX_DMA_DATA, TX_DMA_DATA, TX_DATA;
   logic [7:0] a[7]; // register offsets, last one unmapped
   logic [31:0] m[7]; // writable bits of each
   logic [7:0] p[3]; // pause char per transmit mode
   logic [7:0] rs[3]; // resume char per transmit mode
   int bad_count = 0;
   int comparisons = 0;
   int spc = 0; // cycles with the special pulse high
   // free-running clock
   always #5 REF_CLK = ~REF_CLK;
   // count special pulses where they are settled
   always @(negedge REF_CLK)
      spc <= spc + SPECIAL_CHAR;
   ufc_top dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(1'b1), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID),
      .RX_DATA(RX_DATA), .RX_READY(RX_READY), .FRAME_ERR(err[0]),
      .PARITY_ERR(err[1]), .BREAK_ERR(err[2]), .OVERRUN_ERR(err[3]),
      .RX_DMA_REQ(RX_DMA_REQ), .RX_DMA_DATA(RX_DMA_DATA),
      .RX_DMA_ACK(RX_DMA_ACK), .TX_DMA_REQ(TX_DMA_REQ),
      .TX_DMA_VALID(TX_DMA_VALID), .TX_DMA_DATA(TX_DMA_DATA),
      .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
      .SPECIAL_CHAR(SPECIAL_CHAR));
   ufc_far far (.clk(REF_CLK), .rx_ready(RX_READY), .rx_valid(RX_VALID),
      .rx_data(RX_DATA), .rx_req(RX_DMA_REQ), .rx_dma_data(RX_DMA_DATA),
      .rx_ack(RX_DMA_ACK), .tx_req(TX_DMA_REQ), .tx_dvalid(TX_DMA_VALID),
      .tx_ddata(TX_DMA_DATA), .tx_valid(TX_VALID), .tx_data(TX_DATA),
      .tx_ready(TX_READY));
   // print the counts and the verdict, then stop
   task complete_run;
   begin
      $display("mismatches %0d of %0d checks", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   // compare one value and report a mismatch
   task chk(input logic [31:0] e, input logic [31:0] g);
   begin
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   end
   endtask
   // wait for a rising edge at which the slave is ready
   task wait_rdy;
   begin
      @(posedge REF_CLK);
      while (HREADYOUT !== 1'b1)
         @(posedge REF_CLK);
   end
   endtask
   // one ahb-lite single transfer, address then data phase
   task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
   begin
      @(posedge REF_CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= w;
      HADDR <= {24'h0, ad};
      wait_rdy;
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      wait_rdy;
      r = HRDATA;
   end
   endtask
   // wait a number of falling edges
   task step(input int n);
      repeat (n) @(negedge REF_CLK);
   endtask
   // drive the error inputs just after a rising edge
   task seterr(input logic [3:0] v);
   begin
      @(posedge REF_CLK);
      err <= v;
   end
   endtask
   // oldest byte fetched by the dma
   task chkrx(input logic [7:0] e);
      chk(e, far.rxq.size() ? far.rxq.pop_front() : 9'h1ff);
   endtask
   // oldest byte sent on the line
   task chktx(input logic [7:0] e);
      chk(e, far.txq.size() ? far.txq.pop_front() : 9'h1ff);
   endtask
   // hang guard, far beyond the expected run
   initial
   begin
      repeat (20000) @(posedge REF_CLK);
      bad_count++;
      complete_run;
   end
   // main sequence
   initial
   begin
      RST_N = 1'b0;
      HSEL = 1'b0;
      HWRITE = 1'b0;
      HTRANS = 2'b00;
      HADDR = 32'h0;
      HWDATA = 32'h0;
      err = 4'h0;
      a = '{ADDR_DMA, ADDR_FLOW, ADDR_RES_A, ADDR_RES_B, ADDR_PAU_A,
         ADDR_PAU_B, 8'h00};
      m = '{DMA_MASK, FLOW_MASK, 32'hff, 32'hff, 32'hff, 32'hff, 32'h0};
      p = '{8'h13, 8'h23, 8'h23};
      rs = '{8'h11, 8'h21, 8'h11};
      repeat (2) @(posedge REF_CLK);
      RST_N <= 1'b1;
      ahb(0, ADDR_STATUS, 0);
      chk(REG_RESET, r);
      chk(0, HRESP);
      // reset values, reserved bits and the unmapped place
      for (int i = 0; i < 7; i++)
      begin
         ahb(0, a[i], 0);
         chk(REG_RESET, r);
         ahb(1, a[i], 32'hffffffff);
         ahb(0, a[i], 0);
         chk(m[i], r);
         ahb(1, a[i], 0);
      end
      ahb(1, ADDR_RES_A, 32'h11);
      ahb(1, ADDR_RES_B, 32'h21);
      ahb(1, ADDR_PAU_A, 32'h13);
      ahb(1, ADDR_PAU_B, 32'h23);
      // receive requests only once enabled
      far.send(8'h41);
      step(4);
      chk(0, RX_DMA_REQ);
      ahb(1, ADDR_DMA, 32'h1);
      step(4);
      chkrx(8'h41);
      // each error halts receive requests when asked to
      ahb(1, ADDR_DMA, 32'h9);
      for (int e = 0; e < 4; e++)
      begin
         seterr(4'h1 << e);
         far.send(8'h30 + e);
         step(4);
         chk(0, far.rxq.size());
         ahb(0, ADDR_STATUS, 0);
         chk(32'h80 << e, r);
         seterr(4'h0);
         step(4);
         chkrx(8'h30 + e);
      end
      ahb(1, ADDR_DMA, 32'h1);
      seterr(4'h1);
      far.send(8'h50);
      step(4);
      chkrx(8'h50);
      seterr(4'h0);
      // transmit requests only once enabled
      step(3);
      chk(0, TX_DMA_REQ);
      ahb(1, ADDR_DMA, 32'h3);
      far.dput(8'h61);
      step(6);
      chktx(8'h61);
      // obeyed pause and resume for each transmit mode
      for (int k = 1; k < 4; k++)
      begin
         ahb(1, ADDR_FLOW, (k << 3) | 1);
         far.send(p[k-1]);
         step(3);
         ahb(0, ADDR_STATUS, 0);
         chk(32'h800, r);
         ahb(1, ADDR_STATUS, 32'h800);
         far.dput(8'h70 + k);
         far.send(8'h41);
         step(8);
         chk(0, far.txq.size());
         chkrx(8'h41);
         far.send(rs[k-1]);
         step(6);
         chktx(8'h70 + k);
         chk(0, far.rxq.size());
      end
      // mode off stores pause chars; so does a disabled flow control
      ahb(1, ADDR_FLOW, 32'h1);
      far.send(8'h13);
      ahb(1, ADDR_FLOW, 32'h8);
      far.send(8'h13);
      far.dput(8'h7f);
      step(6);
      chkrx(8'h13);
      chkrx(8'h13);
      chktx(8'h7f);
      // any character resumes and is kept
      ahb(1, ADDR_FLOW, 32'h29);
      far.send(8'h13);
      far.dput(8'h7a);
      step(8);
      chk(0, far.txq.size());
      far.send(8'h41);
      step(6);
      chktx(8'h7a);
      chkrx(8'h41);
      // special detection pulses once per match, only when enabled
      ahb(1, ADDR_FLOW, 32'h0);
      far.send(8'h23);
      step(3);
      chk(0, spc);
      ahb(1, ADDR_FLOW, 32'h40);
      for (int i = 0; i < 4; i++)
      begin
         far.send(p[i % 2] - ((i / 2) * 2));
         step(3);
      end
      chk(4, spc);
      far.rxq.delete();
      // fill the fifo until refused, our pause goes out, drain, resume
      far.slow = 1'b1;
      for (int k = 1; k < 3; k++)
      begin
         ahb(1, ADDR_DMA, 32'h0);
         ahb(1, ADDR_FLOW, (k << 1) | 1);
         for (int i = 0; i < FIFO_DEPTH; i++)
            far.send(8'h80 + i);
         step(20);
         chk(0, RX_READY);
         chktx(p[k-1]);
         ahb(1, ADDR_DMA, 32'h1);
         step(80);
         chk(FIFO_DEPTH, far.rxq.size());
         chkrx(8'h80);
         chktx(rs[k-1]);
         chk(0, RX_DMA_REQ);
         far.rxq.delete();
      end
      complete_run;
   end
endmodule

`default_nettype wire
